// *** shared/gpo_pkg.sv ***
// Shared constants for the three-port GPIO block: register offsets,
// field positions and reset values.
// Assumes an 8-bit register port addressed at the printed offsets.
package gpo_pkg;
   localparam logic [7:0] OFS_P1_DATA = 8'h06;
   localparam logic [7:0] OFS_P2_DATA = 8'h07;
   localparam logic [7:0] OFS_P3_DATA = 8'h08;
   localparam logic [7:0] OFS_IRQ_CTRL = 8'h0B;
   localparam logic [7:0] OFS_OPTION = 8'h81;
   localparam logic [7:0] OFS_P1_DIR = 8'h86;
   localparam logic [7:0] OFS_P2_DIR = 8'h87;
   localparam logic [7:0] OFS_P3_DIR = 8'h88;
   localparam logic [7:0] OFS_P4_DIR_CTRL = 8'h89;
   localparam logic [7:0] OFS_SERIAL_STATUS = 8'h94;

   localparam int OPT_PULLUP_N_BIT = 7;
   localparam int OPT_EDGE_SEL_BIT = 6;
   localparam int IRQ_CHANGE_FLAG_BIT = 0;
   localparam int IRQ_EXT_FLAG_BIT = 1;
   localparam int IRQ_CHANGE_EN_BIT = 3;
   localparam int IRQ_EXT_EN_BIT = 4;
   localparam int P4_PAR_MODE_BIT = 4;
   localparam int SSP_SMBUS_BIT = 6;

   localparam int P1_EXT_IRQ_PIN = 0;
   localparam int P1_PROG_ENTRY_PIN = 3;
   localparam int P1_PROG_CLOCK_PIN = 6;
   localparam int P1_PROG_DATA_PIN = 7;
   localparam int P2_TIMER_OSC_OUT_PIN = 0;
   localparam int P2_TIMER_OSC_IN_PIN = 1;
   localparam int P2_CAPTURE_ONE_PIN = 2;
   localparam int P2_SERIAL_CLOCK_PIN = 3;
   localparam int P2_SERIAL_DATA_PIN = 4;
   localparam int P2_SERIAL_OUT_PIN = 5;
   localparam int P2_UART_TRANSMIT_PIN = 6;
   localparam int P2_UART_RECEIVE_PIN = 7;

   localparam logic [7:0] DIR_RST = 8'hFF;
   localparam logic [7:0] OPTION_RST = 8'hFF;
   localparam logic [7:0] IRQ_RST = 8'h00;
   localparam logic [3:0] P4_CTRL_RST = 4'h7;
   localparam logic IRQ_MASK_BITS_RST = 1'b0;
endpackage

// *** verilog/gpo_pin.sv ***
// One pin driver: chooses port latch or peripheral output and enable.
// Assumes the caller decides when the pin must be kept off the wire.
module gpo_pin
   import gpo_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic latch_bit,
   input wire logic dir_bit,
   input wire logic periph_sel,
   input wire logic periph_oe,
   input wire logic periph_out,
   input wire logic block,
   output logic pin_out_q,
   output logic pin_oe_q
);
   logic oe_d;
   logic out_d;

   always_comb begin
      // Peripheral enable counts only while its select is active
      oe_d = periph_sel ? periph_oe : ~dir_bit;
      oe_d = oe_d & ~block;
      out_d = periph_sel ? periph_out : latch_bit;
      // Latch is unknown after power-up; keep the output defined until driven
      out_d = oe_d ? out_d : 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pin_oe_q <= 1'b0;
         pin_out_q <= 1'b0;
      end else begin
         pin_oe_q <= oe_d;
         pin_out_q <= out_d;
      end
   end
endmodule

// *** verilog/gpo_top.sv ***
// Three 8-bit GPIO ports with pull-ups, change detection and peripheral override.
// Assumes synchronous pin inputs and a one-cycle strobed register port.
//
// Contract
// - Every port-one pin has a weak pull-up under software control.
// - Option bit 7 low enables pull-ups; outputs and reset force them off.
// - Port-one pins 4 to 7 support interrupt-on-change.
// - Input pins 4-7 mismatching last-read value set change flag; reads end mismatch.
// - Port-one pin 0 is external interrupt; Schmitt input while used so.
// - Port-one pin 3 is programming entry in low-voltage mode.
// - Port-one pins 6, 7 serve programming clock/data; Schmitt during programming.
// - Port-two direction 1 tristates the pin, 0 drives the latch.
// - With I2C on, pins 3, 4 take I2C or SMBus levels by status bit 6.
// - Enabled peripheral overrides port-two direction while it stays enabled.
// - Port/peripheral select picks latch or peripheral output per port-two pin.
// - Peripheral enable drives a port-two pin only while its select is active.
// - Port-two pins 0-2 share timer-one oscillator and capture units.
// - Port-two pins 3-7 carry serial clock, data, out and USART lines.
// - Port three is 8 bits, each pin with its own direction bit.
// - Parallel mode bit 4 of port-four control makes port three a TTL slave port.
// - Port reads return pin levels; writes update the output latch.
module gpo_top
   import gpo_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic low_voltage_prog_mode,
   input wire logic serial_prog_mode,
   input wire logic i2c_enable,
   input wire logic [7:0] p1_pin_in,
   output logic [7:0] p1_pin_out,
   output logic [7:0] p1_pin_oe,
   output logic [7:0] p1_pullup_en,
   output logic [7:0] p1_schmitt_sel,
   output logic p1_pin3_prog_entry,
   output logic p1_pin6_prog_clock,
   output logic p1_pin7_prog_data,
   output logic change_irq_flag,
   output logic ext_irq_flag,
   input wire logic [7:0] p2_pin_in,
   output logic [7:0] p2_pin_out,
   output logic [7:0] p2_pin_oe,
   input wire logic [7:0] p2_periph_sel,
   input wire logic [7:0] p2_periph_oe,
   input wire logic [7:0] p2_periph_out,
   output logic [7:0] p2_periph_in,
   output logic [1:0] p2_smbus_levels,
   input wire logic [7:0] p3_pin_in,
   output logic [7:0] p3_pin_out,
   output logic [7:0] p3_pin_oe,
   output logic p3_ttl_sel,
   output logic parallel_port_mode,
   output logic [2:0] p4_direction
);
   logic [7:0] opt_q, opt_d, p1_dir_q, p1_dir_d, p2_dir_q, p2_dir_d, p3_dir_q, p3_dir_d;
   logic [7:0] p1_lat_q, p1_lat_d, p2_lat_q, p2_lat_d, p3_lat_q, p3_lat_d;
   logic [7:0] irq_q, irq_d, rdata_d;
   logic [3:0] p4_ctrl_q, p4_ctrl_d, old_q, old_d;
   logic smbus_q, smbus_d, pin0_prev_q;
   logic [7:0] pull_d, schmitt_d, p1_block;
   logic [1:0] smbus_lv_d;
   logic prog_entry_d, prog_clock_d, prog_data_d;
   logic mismatch, ext_edge, wr_hit_p1, rd_hit_p1;

   assign wr_hit_p1 = reg_wr && reg_addr == OFS_P1_DATA;
   assign rd_hit_p1 = reg_rd && reg_addr == OFS_P1_DATA;
   // Only input pins 4-7 take part in the comparison
   assign mismatch = |((p1_pin_in[7:4] ^ old_q) & p1_dir_q[7:4]);
   assign ext_edge = opt_q[OPT_EDGE_SEL_BIT] ? (p1_pin_in[P1_EXT_IRQ_PIN] & ~pin0_prev_q)
                                              : (~p1_pin_in[P1_EXT_IRQ_PIN] & pin0_prev_q);

   // Register file and event flags
   always_comb begin
      opt_d = opt_q;
      p1_dir_d = p1_dir_q;
      p2_dir_d = p2_dir_q;
      p3_dir_d = p3_dir_q;
      p4_ctrl_d = p4_ctrl_q;
      irq_d = irq_q;
      smbus_d = smbus_q;
      old_d = old_q;
      p1_lat_d = p1_lat_q;
      p2_lat_d = p2_lat_q;
      p3_lat_d = p3_lat_q;
      if (reg_wr) begin
         case (reg_addr)
            OFS_P1_DATA: p1_lat_d = reg_wdata;
            OFS_P2_DATA: p2_lat_d = reg_wdata;
            OFS_P3_DATA: p3_lat_d = reg_wdata;
            OFS_OPTION: opt_d = reg_wdata;
            OFS_P1_DIR: p1_dir_d = reg_wdata;
            OFS_P2_DIR: p2_dir_d = reg_wdata;
            OFS_P3_DIR: p3_dir_d = reg_wdata;
            OFS_P4_DIR_CTRL: p4_ctrl_d = {reg_wdata[P4_PAR_MODE_BIT], reg_wdata[2:0]};
            OFS_IRQ_CTRL: irq_d = reg_wdata & 8'h1B;
            OFS_SERIAL_STATUS: smbus_d = reg_wdata[SSP_SMBUS_BIT];
            default: ;
         endcase
      end
      // A write is read-modify-write too, so it also refreshes the compare value
      if (rd_hit_p1 || wr_hit_p1) begin
         old_d = p1_pin_in[7:4];
      end
      // Hardware set wins over a software clear in the same cycle
      if (mismatch) begin
         irq_d[IRQ_CHANGE_FLAG_BIT] = 1'b1;
      end
      if (ext_edge) begin
         irq_d[IRQ_EXT_FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         opt_q <= OPTION_RST;
         p1_dir_q <= DIR_RST;
         p2_dir_q <= DIR_RST;
         p3_dir_q <= DIR_RST;
         p4_ctrl_q <= P4_CTRL_RST;
         irq_q <= IRQ_RST;
         smbus_q <= IRQ_MASK_BITS_RST;
         // Follow the pins through reset so release shows no false change or edge
         old_q <= p1_pin_in[7:4];
         pin0_prev_q <= p1_pin_in[P1_EXT_IRQ_PIN];
      end else begin
         opt_q <= opt_d;
         p1_dir_q <= p1_dir_d;
         p2_dir_q <= p2_dir_d;
         p3_dir_q <= p3_dir_d;
         p4_ctrl_q <= p4_ctrl_d;
         irq_q <= irq_d;
         smbus_q <= smbus_d;
         old_q <= old_d;
         pin0_prev_q <= p1_pin_in[P1_EXT_IRQ_PIN];
      end
   end

   // Data latches carry no reset: their content survives every reset
   always_ff @(posedge core_clk) begin
      p1_lat_q <= p1_lat_d;
      p2_lat_q <= p2_lat_d;
      p3_lat_q <= p3_lat_d;
   end

   // Read path: pin levels, not latches, for the port data registers
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            OFS_P1_DATA: rdata_d = p1_pin_in;
            OFS_P2_DATA: rdata_d = p2_pin_in;
            OFS_P3_DATA: rdata_d = p3_pin_in;
            OFS_OPTION: rdata_d = opt_q;
            OFS_P1_DIR: rdata_d = p1_dir_q;
            OFS_P2_DIR: rdata_d = p2_dir_q;
            OFS_P3_DIR: rdata_d = p3_dir_q;
            OFS_P4_DIR_CTRL: rdata_d = {3'h0, p4_ctrl_q[3], 1'b0, p4_ctrl_q[2:0]};
            OFS_IRQ_CTRL: rdata_d = irq_q;
            OFS_SERIAL_STATUS: rdata_d = {1'b0, smbus_q, 6'h00};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Pin-function qualifiers for port one and the I2C levels on port two
   always_comb begin
      // Pull-up only on input pins and only while the active-low enable is low
      pull_d = opt_q[OPT_PULLUP_N_BIT] ? 8'h00 : p1_dir_q;
      schmitt_d = 8'h00;
      schmitt_d[P1_EXT_IRQ_PIN] = irq_q[IRQ_EXT_EN_BIT];
      schmitt_d[P1_PROG_CLOCK_PIN] = serial_prog_mode;
      schmitt_d[P1_PROG_DATA_PIN] = serial_prog_mode;
      p1_block = 8'h00;
      p1_block[P1_PROG_ENTRY_PIN] = low_voltage_prog_mode;
      p1_block[P1_PROG_CLOCK_PIN] = serial_prog_mode;
      p1_block[P1_PROG_DATA_PIN] = serial_prog_mode;
      prog_entry_d = low_voltage_prog_mode & p1_pin_in[P1_PROG_ENTRY_PIN];
      prog_clock_d = serial_prog_mode & p1_pin_in[P1_PROG_CLOCK_PIN];
      prog_data_d = serial_prog_mode & p1_pin_in[P1_PROG_DATA_PIN];
      // Each bit set means SMBus thresholds on that serial pin
      smbus_lv_d = (i2c_enable && smbus_q) ? 2'b11 : 2'b00;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
         p1_pullup_en <= 8'h00;
         p1_schmitt_sel <= 8'h00;
         p1_pin3_prog_entry <= 1'b0;
         p1_pin6_prog_clock <= 1'b0;
         p1_pin7_prog_data <= 1'b0;
         p2_periph_in <= 8'h00;
         p2_smbus_levels <= 2'b00;
         p3_ttl_sel <= 1'b0;
         parallel_port_mode <= 1'b0;
         p4_direction <= 3'h7;
         change_irq_flag <= 1'b0;
         ext_irq_flag <= 1'b0;
      end else begin
         reg_rdata <= rdata_d;
         p1_pullup_en <= pull_d;
         p1_schmitt_sel <= schmitt_d;
         p1_pin3_prog_entry <= prog_entry_d;
         p1_pin6_prog_clock <= prog_clock_d;
         p1_pin7_prog_data <= prog_data_d;
         // Peripherals at every port-two position see the pin level
         p2_periph_in <= p2_pin_in;
         p2_smbus_levels <= smbus_lv_d;
         p3_ttl_sel <= p4_ctrl_q[3];
         parallel_port_mode <= p4_ctrl_q[3];
         p4_direction <= p4_ctrl_q[2:0];
         change_irq_flag <= irq_q[IRQ_CHANGE_FLAG_BIT];
         ext_irq_flag <= irq_q[IRQ_EXT_FLAG_BIT];
      end
   end

   // Pin drivers; port three stays off the wire in parallel slave mode
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         gpo_pin u_p1 (
            .core_clk(core_clk), .srst(srst), .latch_bit(p1_lat_q[i]),
            .dir_bit(p1_dir_q[i]), .periph_sel(1'b0), .periph_oe(1'b0),
            .periph_out(1'b0), .block(p1_block[i]),
            .pin_out_q(p1_pin_out[i]), .pin_oe_q(p1_pin_oe[i]));
         gpo_pin u_p2 (
            .core_clk(core_clk), .srst(srst), .latch_bit(p2_lat_q[i]),
            .dir_bit(p2_dir_q[i]), .periph_sel(p2_periph_sel[i]),
            .periph_oe(p2_periph_oe[i]), .periph_out(p2_periph_out[i]), .block(1'b0),
            .pin_out_q(p2_pin_out[i]), .pin_oe_q(p2_pin_oe[i]));
         gpo_pin u_p3 (
            .core_clk(core_clk), .srst(srst), .latch_bit(p3_lat_q[i]),
            .dir_bit(p3_dir_q[i]), .periph_sel(1'b0), .periph_oe(1'b0),
            .periph_out(1'b0), .block(p4_ctrl_q[3]),
            .pin_out_q(p3_pin_out[i]), .pin_oe_q(p3_pin_oe[i]));
      end
   endgenerate

   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   a_read_pin_level: assert property (rd_hit_p1 |=> reg_rdata == $past(p1_pin_in))
      else $error("port one read did not return pin levels");
   a_pullup_gating: assert property (
      ##1 p1_pullup_en == ($past(opt_q[OPT_PULLUP_N_BIT]) ? 8'h00 : $past(p1_dir_q)))
      else $error("pull-up enable wrong for option and direction");
   a_change_flag_set: assert property (
      mismatch |=> irq_q[IRQ_CHANGE_FLAG_BIT] ##1 change_irq_flag)
      else $error("mismatch did not set change flag");
   a_read_ends_mismatch: assert property (
      rd_hit_p1 && $stable(p1_pin_in) [*1] ##1 (p1_pin_in == $past(p1_pin_in)) |-> !mismatch)
      else $error("read did not end mismatch");
   a_p2_port_drive: assert property (
      p2_periph_sel == 8'h00 |=> p2_pin_oe == ~$past(p2_dir_q))
      else $error("port two direction not honoured");
   a_p2_override: assert property (p2_periph_sel != 8'h00 |=>
      (p2_pin_oe & $past(p2_periph_sel)) == $past(p2_periph_sel & p2_periph_oe) &&
      (p2_pin_oe & ~$past(p2_periph_sel)) == $past(~p2_periph_sel & ~p2_dir_q) &&
      (p2_pin_out & $past(p2_periph_sel)) == $past(p2_periph_sel & p2_periph_oe & p2_periph_out))
      else $error("peripheral override not applied");
   a_parallel_off: assert property (
      p4_ctrl_q[3] |=> p3_pin_oe == 8'h00 && p3_ttl_sel)
      else $error("port three driven in parallel mode");
   a_lvp_entry_pin: assert property (low_voltage_prog_mode |=> !p1_pin_oe[3])
      else $error("pin 3 driven in low-voltage programming");
   a_prog_schmitt: assert property (serial_prog_mode [*2] |=>
      p1_schmitt_sel[7:6] == 2'b11 && p1_pin_oe[7:6] == 2'b00)
      else $error("programming pins not switched");
   a_ext_schmitt: assert property (
      ##1 p1_schmitt_sel[0] == $past(irq_q[IRQ_EXT_EN_BIT]))
      else $error("external interrupt buffer select wrong");
   a_smbus_levels: assert property (
      i2c_enable && smbus_q |=> p2_smbus_levels == 2'b11)
      else $error("SMBus levels not selected");
   a_dir_reset: assert property (@(posedge core_clk) disable iff (1'b0)
      srst |=> p1_dir_q == DIR_RST && p2_dir_q == DIR_RST && p3_dir_q == DIR_RST)
      else $error("direction registers not reset to inputs");

   c_change_irq: cover property (mismatch ##1 rd_hit_p1);
   c_override: cover property (p2_periph_sel != 8'h00 && p2_periph_oe != 8'h00);
   c_parallel: cover property ($rose(p4_ctrl_q[3]));
   c_ext_edge: cover property (ext_edge && irq_q[IRQ_EXT_EN_BIT]);
endmodule

// *** tb/gpo_pin_model.sv ***
// Pin-side model of one 8-bit port: resolves the wire from driver, outside source and pull-up.
// Assumes the bench sets the outside source and whether it is connected.
module gpo_pin_model
(
   input wire logic core_clk,
   input wire logic [7:0] oe,
   input wire logic [7:0] out,
   input wire logic [7:0] pull,
   input wire logic [7:0] ext,
   input wire logic [7:0] ext_en,
   output logic [7:0] lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_q;
   always_ff @(posedge core_clk) begin
      last_q <= lvl;
   end
   // A floating pin without pull-up flips each cycle so a stale value can never pass
   assign lvl = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pull | ~last_q));
endmodule

// *** tb/gpo_top_tb.sv ***
// Self-checking bench for the three-port GPIO block.
// Assumes the register port answers reads one cycle later and pins settle within three cycles.
module gpo_top_tb
   import gpo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic low_voltage_prog_mode = 1'b0, serial_prog_mode = 1'b0, i2c_enable = 1'b0;
   logic [7:0] p1_pin_in, p1_pin_out, p1_pin_oe, p1_pullup_en, p1_schmitt_sel;
   logic p1_pin3_prog_entry, p1_pin6_prog_clock, p1_pin7_prog_data, change_irq_flag, ext_irq_flag;
   logic [7:0] p2_pin_in, p2_pin_out, p2_pin_oe, p2_periph_in;
   logic [7:0] p2_periph_sel = 8'h00, p2_periph_oe = 8'h00, p2_periph_out = 8'h00;
   logic [1:0] p2_smbus_levels;
   logic [7:0] p3_pin_in, p3_pin_out, p3_pin_oe;
   logic p3_ttl_sel, parallel_port_mode;
   logic [2:0] p4_direction;
   logic [7:0] ext1 = 8'h00, ext2 = 8'h00, ext3 = 8'h00, en1 = 8'hFF, all_on = 8'hFF;
   int mismatches = 0, samples_checked = 0;

   always #5 core_clk = ~core_clk;

   gpo_top dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .low_voltage_prog_mode(low_voltage_prog_mode), .serial_prog_mode(serial_prog_mode),
      .i2c_enable(i2c_enable), .p1_pin_in(p1_pin_in), .p1_pin_out(p1_pin_out),
      .p1_pin_oe(p1_pin_oe), .p1_pullup_en(p1_pullup_en), .p1_schmitt_sel(p1_schmitt_sel),
      .p1_pin3_prog_entry(p1_pin3_prog_entry), .p1_pin6_prog_clock(p1_pin6_prog_clock),
      .p1_pin7_prog_data(p1_pin7_prog_data), .change_irq_flag(change_irq_flag),
      .ext_irq_flag(ext_irq_flag), .p2_pin_in(p2_pin_in), .p2_pin_out(p2_pin_out),
      .p2_pin_oe(p2_pin_oe), .p2_periph_sel(p2_periph_sel), .p2_periph_oe(p2_periph_oe),
      .p2_periph_out(p2_periph_out), .p2_periph_in(p2_periph_in),
      .p2_smbus_levels(p2_smbus_levels), .p3_pin_in(p3_pin_in), .p3_pin_out(p3_pin_out),
      .p3_pin_oe(p3_pin_oe), .p3_ttl_sel(p3_ttl_sel), .parallel_port_mode(parallel_port_mode),
      .p4_direction(p4_direction));
   gpo_pin_model m1 (.core_clk(core_clk), .oe(p1_pin_oe), .out(p1_pin_out), .pull(p1_pullup_en),
      .ext(ext1), .ext_en(en1), .lvl(p1_pin_in));
   gpo_pin_model m2 (.core_clk(core_clk), .oe(p2_pin_oe), .out(p2_pin_out), .pull(8'h00),
      .ext(ext2), .ext_en(all_on), .lvl(p2_pin_in));
   gpo_pin_model m3 (.core_clk(core_clk), .oe(p3_pin_oe), .out(p3_pin_out), .pull(8'h00),
      .ext(ext3), .ext_en(all_on), .lvl(p3_pin_in));

   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic settle;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   initial begin
      #100us;
      mismatches++;
      print_verdict;
   end

   initial begin
      logic [7:0] v, d1, l1, d2, l2, s, po, pv, eo, ev;
      void'($urandom(14));
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      rchk(OFS_P1_DIR, DIR_RST);
      rchk(OFS_P2_DIR, DIR_RST);
      rchk(OFS_P3_DIR, DIR_RST);
      rchk(OFS_OPTION, OPTION_RST);
      rchk(OFS_IRQ_CTRL, IRQ_RST);
      rchk(8'h00, 8'h00);
      chk(p1_pullup_en, 8'h00);
      chk(p2_pin_oe, 8'h00);
      for (int i = 0; i < 8; i++) begin
         d1 = $urandom;
         l1 = $urandom;
         v = $urandom;
         @(posedge core_clk);
         ext1 <= v;
         wr(OFS_P1_DATA, l1);
         wr(OFS_P1_DIR, d1);
         wr(OFS_OPTION, {i[0], 7'h7F});
         settle;
         chk(p1_pin_oe, ~d1);
         chk(p1_pin_out, l1 & ~d1);
         chk(p1_pullup_en, i[0] ? 8'h00 : d1);
         rchk(OFS_P1_DATA, (l1 & ~d1) | (v & d1));
      end
      // Disconnected inputs with pull-ups on must read high
      wr(OFS_OPTION, 8'h7F);
      wr(OFS_P1_DIR, 8'hFF);
      @(posedge core_clk);
      en1 <= 8'h00;
      settle;
      rchk(OFS_P1_DATA, 8'hFF);
      @(posedge core_clk);
      en1 <= 8'hFF;
      wr(OFS_P1_DIR, 8'hF7);
      low_voltage_prog_mode <= 1'b1;
      settle;
      chk(p1_pullup_en, 8'hF7);
      chk(p1_pin_oe, 8'h00);
      chk({7'h00, p1_pin3_prog_entry}, {7'h00, v[3]});
      @(posedge core_clk);
      serial_prog_mode <= 1'b1;
      wr(OFS_P1_DIR, 8'h00);
      settle;
      chk(p1_pin_oe, 8'h37);
      chk({6'h00, p1_schmitt_sel[7:6]}, 8'h03);
      chk({6'h00, p1_pin7_prog_data, p1_pin6_prog_clock}, {6'h00, v[7:6]});
      @(posedge core_clk);
      low_voltage_prog_mode <= 1'b0;
      serial_prog_mode <= 1'b0;
      wr(OFS_OPTION, 8'hFF);
      wr(OFS_P1_DIR, 8'hFF);
      @(posedge core_clk);
      ext1 <= 8'h00;
      settle;
      rchk(OFS_P1_DATA, 8'h00);
      wr(OFS_IRQ_CTRL, 8'h00);
      rchk(OFS_IRQ_CTRL, 8'h00);
      @(posedge core_clk);
      ext1 <= 8'h80;
      settle;
      rchk(OFS_IRQ_CTRL, 8'h01);
      chk({7'h00, change_irq_flag}, 8'h01);
      wr(OFS_IRQ_CTRL, 8'h00);
      rchk(OFS_IRQ_CTRL, 8'h01);
      rchk(OFS_P1_DATA, 8'h80);
      wr(OFS_IRQ_CTRL, 8'h00);
      wr(OFS_P1_DIR, 8'h0F);
      @(posedge core_clk);
      ext1 <= 8'h70;
      settle;
      rchk(OFS_IRQ_CTRL, 8'h00);
      wr(OFS_P1_DIR, 8'hFF);
      @(posedge core_clk);
      ext1 <= 8'h80;
      settle;
      // Pins 4-7 turning back to inputs count as a change: re-read and clear first
      rchk(OFS_P1_DATA, 8'h80);
      wr(OFS_IRQ_CTRL, 8'h00);
      @(posedge core_clk);
      ext1 <= 8'h81;
      settle;
      rchk(OFS_IRQ_CTRL, 8'h02);
      chk({7'h00, ext_irq_flag}, 8'h01);
      wr(OFS_IRQ_CTRL, 8'h10);
      settle;
      chk({7'h00, p1_schmitt_sel[0]}, 8'h01);
      rchk(OFS_IRQ_CTRL, 8'h10);
      for (int i = 0; i < 24; i++) begin
         d2 = $urandom;
         l2 = $urandom;
         s = $urandom;
         po = $urandom;
         pv = $urandom;
         v = $urandom;
         @(posedge core_clk);
         p2_periph_sel <= s;
         p2_periph_oe <= po;
         p2_periph_out <= pv;
         ext2 <= v;
         wr(OFS_P2_DATA, l2);
         wr(OFS_P2_DIR, d2);
         settle;
         eo = (s & po) | (~s & ~d2);
         ev = eo & ((s & pv) | (~s & l2));
         chk(p2_pin_oe, eo);
         chk(p2_pin_out, ev);
         chk(p2_periph_in, ev | (v & ~eo));
         rchk(OFS_P2_DATA, ev | (v & ~eo));
      end
      @(posedge core_clk);
      i2c_enable <= 1'b1;
      wr(OFS_SERIAL_STATUS, 8'h40);
      settle;
      chk({6'h00, p2_smbus_levels}, 8'h03);
      rchk(OFS_SERIAL_STATUS, 8'h40);
      wr(OFS_SERIAL_STATUS, 8'h00);
      settle;
      chk({6'h00, p2_smbus_levels}, 8'h00);
      d1 = $urandom;
      l1 = $urandom;
      wr(OFS_P3_DATA, l1);
      wr(OFS_P3_DIR, d1);
      settle;
      chk(p3_pin_oe, ~d1);
      chk(p3_pin_out, l1 & ~d1);
      rchk(OFS_P3_DATA, l1 & ~d1);
      chk({7'h00, p3_ttl_sel}, 8'h00);
      wr(OFS_P4_DIR_CTRL, 8'h15);
      settle;
      chk(p3_pin_oe, 8'h00);
      chk({6'h00, p3_ttl_sel, parallel_port_mode}, 8'h03);
      chk({5'h00, p4_direction}, 8'h05);
      rchk(OFS_P4_DIR_CTRL, 8'h15);
      // Second reset mid-run: directions return to inputs, latch must survive
      @(posedge core_clk);
      p2_periph_sel <= 8'h00;
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      rchk(OFS_P2_DIR, DIR_RST);
      wr(OFS_P2_DIR, 8'h00);
      settle;
      chk(p2_pin_out, l2);
      print_verdict;
   end
endmodule
